// *** host_model.sv ***
/*
 host model: loads the buffer address tables through write strobes.
 assumes the clock of the setup controls; data inverted when idle.
*/
`timescale 1ns/1ns
`default_nettype none
module host_model (
	input wire logic clk_in,
	output var nic_setup_pkg::table_write_s tx_table_out,
	output var nic_setup_pkg::table_write_s rx_table_out
);
	import nic_setup_pkg::*;
	table_write_s w;
	initial begin
		tx_table_out = '0;
		rx_table_out = '0;
	end
	// one strobe: kind 0 index, 1 high half, 2 low half
	task automatic put(input logic rx, input int kind, input logic [31:0] d);
		w = '0;
		w.data = d;
		w.index_write = (kind == 0);
		w.high_write = (kind == 1);
		w.low_write = (kind == 2);
		@(posedge clk_in);
		if (rx) begin
			rx_table_out <= w;
		end else begin
			tx_table_out <= w;
		end
		@(posedge clk_in);
		w = '0;
		w.data = ~d;
		if (rx) begin
			rx_table_out <= w;
		end else begin
			tx_table_out <= w;
		end
		@(negedge clk_in);
	endtask
	// index, then high half, then low half
	task automatic load(input logic rx, input logic [5:0] i,
		input logic [63:0] a);
		put(rx, 0, {26'h0, i});
		put(rx, 1, a[63:32]);
		put(rx, 2, a[31:0]);
	endtask
endmodule // host_model
`default_nettype wire

// *** nic_host_setup_controls.sv ***
/*
 setup controls: address tables, mode enables, loopback, receive
 command queue counters, packet available and interrupt request.
 assumes all inputs synchronous to clk_in and strobes one cycle wide.
*/
`timescale 1ns/1ns
`default_nettype none
`include "nic_setup_map.svh"

module nic_host_setup_controls (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire nic_setup_pkg::table_write_s tx_table_in,
	input wire nic_setup_pkg::table_write_s rx_table_in,
	input wire logic [`TABLE_INDEX_BITS-1:0] tx_lookup_index_in,
	input wire logic [`TABLE_INDEX_BITS-1:0] rx_lookup_index_in,
	input wire logic transmitter_enable_in,
	input wire logic receiver_enable_in,
	input wire logic [`LOOPBACK_BITS-1:0] loopback_select_in,
	input wire logic global_interrupt_enable_in,
	input wire logic receive_descriptor_done_mask_in,
	input wire logic receive_fifo_packet_mask_in,
	input wire logic programmed_io_tx_frame_in,
	input wire logic packet_descriptor_list_tx_start_in,
	input wire logic packet_descriptor_command_tx_start_in,
	input wire logic packet_descriptor_list_rx_command_in,
	input wire logic packet_descriptor_command_rx_command_in,
	input wire logic line_rx_frame_in,
	input wire logic rx_fifo_packet_read_in,
	input wire logic rx_buffer_filled_in,
	input wire logic done_count_clear_in,
	input wire logic interrupt_ack_in,
	output logic [`TABLE_INDEX_BITS-1:0] tx_buffer_table_index_out,
	output logic [`TABLE_INDEX_BITS-1:0] rx_buffer_table_index_out,
	output logic [2*`ADDR_HALF_BITS-1:0] tx_table_address_out,
	output logic [2*`ADDR_HALF_BITS-1:0] rx_table_address_out,
	output logic transmitter_active_out,
	output logic receiver_active_out,
	output logic loopback_active_out,
	output logic tx_frame_start_out,
	output nic_setup_pkg::method_e tx_method_out,
	output logic rx_command_accept_out,
	output nic_setup_pkg::method_e rx_command_method_out,
	output logic receive_packet_available_out,
	output logic [`RX_CMD_COUNT_BITS-1:0] receive_command_free_count_out,
	output logic [`DONE_COUNT_BITS-1:0] receive_transfer_done_count_out,
	output logic interrupt_request_out
);
	import nic_setup_pkg::*;

	state_s state;
	state_s next_state;
	logic [2*`ADDR_HALF_BITS-1:0] tx_table [0:`TABLE_ENTRIES-1];
	logic [2*`ADDR_HALF_BITS-1:0] rx_table [0:`TABLE_ENTRIES-1];
	logic loopback_on;
	logic tx_frame;
	logic rx_frame;
	logic pkt_push;
	logic pkt_pop;
	logic rx_cmd_req;
	logic rx_cmd_ok;
	logic done_event;

	// next table index after a host write
	function automatic logic [`TABLE_INDEX_BITS-1:0] next_index(
		input table_write_s wr,
		input logic [`TABLE_INDEX_BITS-1:0] index
	);
		if (wr.index_write) begin
			next_index = wr.data[`TABLE_INDEX_BITS-1:0];
		end else if (wr.low_write) begin
			next_index = index + `TABLE_INDEX_BITS'(1);
		end else begin
			next_index = index;
		end
	endfunction

	// stored high half for a table
	function automatic logic [`ADDR_HALF_BITS-1:0] next_high(
		input table_write_s wr,
		input logic [`ADDR_HALF_BITS-1:0] high
	);
		next_high = wr.high_write ? wr.data : high;
	endfunction

	always_comb begin
		loopback_on = loopback_select_in != `LOOPBACK_OFF;
		tx_frame = state.tx_start;
		// frames from the line are ignored while looped back
		rx_frame = loopback_on ? tx_frame : line_rx_frame_in;
		pkt_push = rx_frame && state.rx_active;
		pkt_pop = rx_fifo_packet_read_in && state.pkt_count != '0;
		rx_cmd_req = packet_descriptor_list_rx_command_in ||
			packet_descriptor_command_rx_command_in;
		rx_cmd_ok = rx_cmd_req && state.rx_free != '0;
		done_event = rx_buffer_filled_in &&
			state.rx_free != `RX_CMD_DEPTH;
	end

	always_comb begin
		next_state = state;
		next_state.tx_index = next_index(tx_table_in, state.tx_index);
		next_state.rx_index = next_index(rx_table_in, state.rx_index);
		next_state.tx_high = next_high(tx_table_in, state.tx_high);
		next_state.rx_high = next_high(rx_table_in, state.rx_high);
		next_state.tx_active = transmitter_enable_in;
		next_state.rx_active = receiver_enable_in;
		// one frame per cycle; pio wins, then list, then command buffer
		next_state.tx_start = state.tx_active && (programmed_io_tx_frame_in ||
			packet_descriptor_list_tx_start_in ||
			packet_descriptor_command_tx_start_in);
		if (programmed_io_tx_frame_in) begin
			next_state.tx_method = method_pio;
		end else if (packet_descriptor_list_tx_start_in) begin
			next_state.tx_method = method_pdl;
		end else if (packet_descriptor_command_tx_start_in) begin
			next_state.tx_method = method_pdc;
		end
		if (pkt_push && !pkt_pop &&
				state.pkt_count != {`PKT_COUNT_BITS{1'b1}}) begin
			next_state.pkt_count = state.pkt_count + `PKT_COUNT_BITS'(1);
		end else if (pkt_pop && !pkt_push) begin
			next_state.pkt_count = state.pkt_count - `PKT_COUNT_BITS'(1);
		end
		next_state.rx_cmd_accept = rx_cmd_ok;
		if (packet_descriptor_list_rx_command_in) begin
			next_state.rx_cmd_method = method_pdl;
		end else if (packet_descriptor_command_rx_command_in) begin
			next_state.rx_cmd_method = method_pdc;
		end
		case ({rx_cmd_ok, done_event})
			2'b10: begin
				next_state.rx_free = state.rx_free - `RX_CMD_COUNT_BITS'(1);
			end
			2'b01: begin
				next_state.rx_free = state.rx_free + `RX_CMD_COUNT_BITS'(1);
			end
			default: begin
				next_state.rx_free = state.rx_free;
			end
		endcase
		// set wins over clear
		if (done_count_clear_in) begin
			next_state.done_count = done_event ?
				`DONE_COUNT_BITS'(1) : '0;
		end else if (done_event &&
				state.done_count != {`DONE_COUNT_BITS{1'b1}}) begin
			next_state.done_count = state.done_count +
				`DONE_COUNT_BITS'(1);
		end
		if (done_event) begin
			next_state.done_pending = 1'b1;
		end else if (interrupt_ack_in) begin
			next_state.done_pending = 1'b0;
		end
		next_state.tx_lookup = tx_table[tx_lookup_index_in];
		next_state.rx_lookup = rx_table[rx_lookup_index_in];
		if (rst_in) begin
			next_state.tx_index = `RESET_INDEX;
			next_state.rx_index = `RESET_INDEX;
			next_state.tx_high = `RESET_HALF;
			next_state.rx_high = `RESET_HALF;
			next_state.pkt_count = '0;
			next_state.rx_free = `RX_CMD_DEPTH;
			next_state.done_count = '0;
			next_state.done_pending = 1'b0;
			next_state.tx_active = 1'b0;
			next_state.rx_active = 1'b0;
			next_state.tx_start = 1'b0;
			next_state.tx_method = method_pio;
			next_state.rx_cmd_accept = 1'b0;
			next_state.rx_cmd_method = method_pdl;
			next_state.tx_lookup = '0;
			next_state.rx_lookup = '0;
		end
	end

	always_ff @(posedge clk_in) begin
		state <= next_state;
	end

	// tables are not cleared by reset; unfilled entries are don't care
	always_ff @(posedge clk_in) begin
		if (!rst_in && tx_table_in.low_write) begin
			tx_table[state.tx_index] <= {state.tx_high, tx_table_in.data};
		end
		if (!rst_in && rx_table_in.low_write) begin
			rx_table[state.rx_index] <= {state.rx_high, rx_table_in.data};
		end
	end

	always_comb begin
		tx_buffer_table_index_out = state.tx_index;
		rx_buffer_table_index_out = state.rx_index;
		tx_table_address_out = state.tx_lookup;
		rx_table_address_out = state.rx_lookup;
		transmitter_active_out = state.tx_active;
		receiver_active_out = state.rx_active;
		loopback_active_out = loopback_on;
		tx_frame_start_out = state.tx_start;
		tx_method_out = state.tx_method;
		rx_command_accept_out = state.rx_cmd_accept;
		rx_command_method_out = state.rx_cmd_method;
		receive_packet_available_out = state.pkt_count != '0;
		receive_command_free_count_out = state.rx_free;
		receive_transfer_done_count_out = state.done_count;
		interrupt_request_out = global_interrupt_enable_in &&
			((receive_descriptor_done_mask_in && state.done_pending) ||
			(receive_fifo_packet_mask_in && state.pkt_count != '0));
	end

endmodule // nic_host_setup_controls

`default_nettype wire

// *** nic_host_setup_controls_tb.sv ***
/*
 self-checking bench of the setup controls with a host model.
 assumes the checker is bound to the design.
*/
`timescale 1ns/1ns
`default_nettype none
module nic_host_setup_controls_tb;
	import nic_setup_pkg::*;
	logic clk_in = 1'h0;
	logic rst_in = 1'h1;
	nic_setup_pkg::table_write_s tx_table_in, rx_table_in;
	logic [5:0] tx_lookup_index_in = '0, rx_lookup_index_in = '0, i;
	logic transmitter_enable_in = '0, receiver_enable_in = '0;
	logic [1:0] loopback_select_in = '0;
	logic global_interrupt_enable_in = '0, receive_descriptor_done_mask_in = '0;
	logic receive_fifo_packet_mask_in = '0;
	logic [9:0] st = '0;
	wire logic interrupt_ack_in, done_count_clear_in, rx_buffer_filled_in,
		rx_fifo_packet_read_in, line_rx_frame_in,
		packet_descriptor_command_rx_command_in,
		packet_descriptor_list_rx_command_in,
		packet_descriptor_command_tx_start_in,
		packet_descriptor_list_tx_start_in, programmed_io_tx_frame_in;
	logic [5:0] tx_buffer_table_index_out, rx_buffer_table_index_out;
	logic [5:0] receive_command_free_count_out, receive_transfer_done_count_out;
	logic [63:0] tx_table_address_out, rx_table_address_out, a, b, c;
	logic transmitter_active_out, receiver_active_out, loopback_active_out,
		tx_frame_start_out, rx_command_accept_out, receive_packet_available_out,
		interrupt_request_out;
	method_e tx_method_out, rx_command_method_out;
	int error_cnt = 0, check_count = 0, k;
	assign {interrupt_ack_in, done_count_clear_in, rx_buffer_filled_in,
		rx_fifo_packet_read_in, line_rx_frame_in,
		packet_descriptor_command_rx_command_in,
		packet_descriptor_list_rx_command_in,
		packet_descriptor_command_tx_start_in,
		packet_descriptor_list_tx_start_in, programmed_io_tx_frame_in} = st;
	nic_host_setup_controls DUT (.*);
	host_model host (.clk_in(clk_in), .tx_table_out(tx_table_in),
		.rx_table_out(rx_table_in));
	always #50 clk_in = ~clk_in;
	function automatic logic irq_of(logic g, d, p, f, v);
		return g & ((d & p) | (f & v));
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic pulse(input logic [9:0] m);
		@(posedge clk_in);
		st <= m;
		@(posedge clk_in);
		st <= '0;
		@(negedge clk_in);
	endtask
	task automatic peek(input logic [5:0] t, input logic [5:0] r);
		@(posedge clk_in);
		tx_lookup_index_in <= t;
		rx_lookup_index_in <= r;
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk_in);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'hC9F2));
		a = {$urandom(), $urandom()};
		b = {$urandom(), $urandom()};
		c = {$urandom(), $urandom()};
		i = 6'($urandom());
		repeat (3) @(posedge clk_in);
		rst_in <= 1'h0;
		@(negedge clk_in);
		chk(receive_command_free_count_out, 6'h20);
		host.load(1'h0, 6'h3F, a);
		host.put(1'h0, 1, b[63:32]);
		host.put(1'h0, 2, b[31:0]);
		host.load(1'h1, i, c);
		chk(tx_buffer_table_index_out, 6'h01);
		chk(rx_buffer_table_index_out, 6'(i + 6'h01));
		peek(6'h3F, i);
		chk(tx_table_address_out, a);
		chk(rx_table_address_out, c);
		peek(6'h00, i);
		chk(tx_table_address_out, b);
		$display("tables done");
		pulse(10'h001);
		chk(tx_frame_start_out, 1'h0);
		@(posedge clk_in);
		transmitter_enable_in <= 1'h1;
		for (k = 0; k < 4; k++) begin
			pulse(k < 3 ? 10'h001 << k : 10'h007);
			chk(tx_frame_start_out, 1'h1);
			chk(tx_method_out, method_e'(k % 3));
		end
		$display("transmit methods done");
		@(posedge clk_in);
		receiver_enable_in <= 1'h1;
		loopback_select_in <= 2'($urandom_range(3, 1));
		global_interrupt_enable_in <= 1'h1;
		receive_fifo_packet_mask_in <= 1'h1;
		pulse(10'h004);
		@(negedge clk_in);
		chk(receive_packet_available_out, 1'h1);
		chk(interrupt_request_out, irq_of(1, 0, 0, 1, 1));
		@(posedge clk_in);
		global_interrupt_enable_in <= 1'h0;
		@(negedge clk_in);
		chk(interrupt_request_out, 1'h0);
		pulse(10'h040);
		chk(receive_packet_available_out, 1'h0);
		chk(loopback_active_out, 1'h1);
		pulse(10'h020);
		chk(receive_packet_available_out, 1'h0);
		@(posedge clk_in);
		loopback_select_in <= 2'h0;
		pulse(10'h020);
		chk(loopback_active_out, 1'h0);
		chk(receive_packet_available_out, 1'h1);
		pulse(10'h040);
		chk(receive_packet_available_out, 1'h0);
		$display("loopback done");
		@(posedge clk_in);
		global_interrupt_enable_in <= 1'h1;
		receive_descriptor_done_mask_in <= 1'h1;
		for (k = 0; k < 3; k++) begin
			pulse(k == 2 ? 10'h018 : 10'h008 << k);
			chk(rx_command_accept_out, 1'h1);
			chk(rx_command_method_out, method_e'(k == 1 ? 2 : 1));
			chk(receive_command_free_count_out, 6'(31 - k));
		end
		pulse(10'h080);
		chk(receive_transfer_done_count_out, 6'h01);
		chk(receive_command_free_count_out, 6'h1E);
		chk(interrupt_request_out, irq_of(1, 1, 1, 1, 0));
		pulse(10'h200);
		chk(interrupt_request_out, 1'h0);
		pulse(10'h180);
		chk(receive_transfer_done_count_out, 6'h01);
		chk(receive_command_free_count_out, 6'h1F);
		chk(interrupt_request_out, irq_of(1, 1, 1, 1, 0));
		@(posedge clk_in);
		transmitter_enable_in <= 1'h0;
		receiver_enable_in <= 1'h0;
		@(posedge clk_in);
		@(negedge clk_in);
		chk({transmitter_active_out, receiver_active_out}, 2'h0);
		$display("receive commands done");
		tally_and_finish();
	end
endmodule // nic_host_setup_controls_tb
`default_nettype wire

// *** nic_setup_map.svh ***
/*
 setup control constants: table sizes, queue depth, reset values.
 assumes inclusion by the package and the control module only.
*/
// Contract
// - writing tx address low half bumps the tx table index by one
// - writing rx address low half bumps the rx table index by one
// - tx address table holds 64 entries, indexed writes of both halves
// - rx address table holds 64 entries; host may leave some unfilled
// - descriptor-done mask raises interrupt per filled host buffer
// - fifo mask raises interrupt while a complete packet waits
// - no interrupt unless global interrupt enable is set
// - setting tx and rx enables activates transmitter and receiver
// - clearing tx and rx enables stops transmitter and receiver
// - loopback select routes transmitted frames into own receiver
// - packet available flag set while receive fifo holds a packet
// - transfer done count goes non-zero after a bus-master receive
// - free count reports receive command entries still open
// - loopback accepts frames from pio and both bus-master methods
// - list and command-buffer receives share one command queue
// - method chosen by which start strobe the host writes
`ifndef NIC_SETUP_MAP_SVH
`define NIC_SETUP_MAP_SVH

`define TABLE_ENTRIES 64
`define TABLE_INDEX_BITS 6
`define ADDR_HALF_BITS 32
`define RX_CMD_DEPTH 6'h20
`define RX_CMD_COUNT_BITS 6
`define DONE_COUNT_BITS 6
`define PKT_COUNT_BITS 8
`define LOOPBACK_BITS 2
`define LOOPBACK_OFF 2'h0
`define RESET_INDEX 6'h00
`define RESET_HALF 32'h00000000

`endif

// *** nic_setup_pkg.sv ***
/*
 types of the setup control block.
 assumes the map header is in the include path.
*/
`default_nettype none
`include "nic_setup_map.svh"

package nic_setup_pkg;

	typedef enum logic [1:0] {
		method_pio,
		method_pdl,
		method_pdc
	} method_e;

	// host writes to one address table
	typedef struct packed {
		logic index_write;
		logic high_write;
		logic low_write;
		logic [`ADDR_HALF_BITS-1:0] data;
	} table_write_s;

	typedef struct packed {
		logic [`TABLE_INDEX_BITS-1:0] tx_index;
		logic [`TABLE_INDEX_BITS-1:0] rx_index;
		logic [`ADDR_HALF_BITS-1:0] tx_high;
		logic [`ADDR_HALF_BITS-1:0] rx_high;
		logic [`PKT_COUNT_BITS-1:0] pkt_count;
		logic [`RX_CMD_COUNT_BITS-1:0] rx_free;
		logic [`DONE_COUNT_BITS-1:0] done_count;
		logic done_pending;
		logic tx_active;
		logic rx_active;
		logic tx_start;
		method_e tx_method;
		logic rx_cmd_accept;
		method_e rx_cmd_method;
		logic [2*`ADDR_HALF_BITS-1:0] tx_lookup;
		logic [2*`ADDR_HALF_BITS-1:0] rx_lookup;
	} state_s;

endpackage

`default_nettype wire

// *** setup_checker_assertions.sv ***
/*
 concurrent checks on the setup controls' ports.
 assumes binding into nic_host_setup_controls, one clock, sync reset.
*/
`timescale 1ns/1ns
`default_nettype none
module setup_checker (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire nic_setup_pkg::table_write_s tx_table_in,
	input wire logic transmitter_enable_in,
	input wire logic receiver_enable_in,
	input wire logic global_interrupt_enable_in,
	input wire logic receive_descriptor_done_mask_in,
	input wire logic receive_fifo_packet_mask_in,
	input wire logic programmed_io_tx_frame_in,
	input wire logic packet_descriptor_list_tx_start_in,
	input wire logic packet_descriptor_command_tx_start_in,
	input wire logic packet_descriptor_list_rx_command_in,
	input wire logic packet_descriptor_command_rx_command_in,
	input wire logic rx_fifo_packet_read_in,
	input wire logic rx_buffer_filled_in,
	input wire logic [5:0] tx_buffer_table_index_out,
	input wire logic transmitter_active_out,
	input wire logic receiver_active_out,
	input wire logic loopback_active_out,
	input wire logic tx_frame_start_out,
	input wire logic rx_command_accept_out,
	input wire logic receive_packet_available_out,
	input wire logic [5:0] receive_command_free_count_out,
	input wire logic interrupt_request_out
);
	import nic_setup_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// frame offered while transmitter runs
	sequence tx_offer;
		(programmed_io_tx_frame_in || packet_descriptor_list_tx_start_in
		|| packet_descriptor_command_tx_start_in) && transmitter_active_out;
	endsequence
	// buffer filled with a command outstanding
	sequence done_event;
		rx_buffer_filled_in && receive_command_free_count_out != 6'h20;
	endsequence
	a_tx_index_step: assert property (tx_table_in.low_write
		&& !tx_table_in.index_write |=> tx_buffer_table_index_out ==
		$past(tx_buffer_table_index_out) + 6'h01) else $error("tx index");
	a_irq_global_gate: assert property (!global_interrupt_enable_in
		|-> !interrupt_request_out) else $error("irq without enable");
	a_fifo_irq: assert property (global_interrupt_enable_in
		&& receive_fifo_packet_mask_in && receive_packet_available_out
		|-> interrupt_request_out) else $error("fifo irq missing");
	a_done_irq: assert property (done_event ##1 (global_interrupt_enable_in
		&& receive_descriptor_done_mask_in) |-> interrupt_request_out)
		else $error("done irq missing");
	a_mode_enables: assert property (1'h1 |=> transmitter_active_out ==
		$past(transmitter_enable_in) && receiver_active_out ==
		$past(receiver_enable_in)) else $error("enable follow");
	a_loop_packet: assert property (tx_frame_start_out && loopback_active_out
		&& receiver_active_out && !rx_fifo_packet_read_in
		|=> receive_packet_available_out) else $error("loop packet");
	a_cmd_take: assert property ((packet_descriptor_list_rx_command_in
		|| packet_descriptor_command_rx_command_in) && !rx_buffer_filled_in
		&& receive_command_free_count_out != 6'h00 |=> rx_command_accept_out
		&& receive_command_free_count_out ==
		$past(receive_command_free_count_out) - 6'h01) else $error("cmd take");
	a_tx_start: assert property (tx_offer |=> tx_frame_start_out)
		else $error("tx start missing");
endmodule // setup_checker
bind nic_host_setup_controls setup_checker chk_i (.*);
`default_nettype wire
